//--- core/sfp_params.svh
// Functional notes
// - Almost-full flag sets at threshold; status-one read clears
// - Data read clears both FIFO flags when enabled
// - New-sample flag bit 5, cleared by read
// - Frequency-lock-lost bit 4, reasserts while unlocked
// - Frequency-locked bit 3, reasserts while locked
// - Phase-lock-lost bit 2 only after prior lock
// - Phase-locked bit 1, reasserts while locked
// - Undervoltage flag resets to one, resets registers
// - Soft reset spares flag; read or shutdown clears
// - Undervoltage flag always drives interrupt pin
// - Lead-on flag bit 7 of status two
// - Over-threshold flag after 128/125 ms persistence
// - Threshold flags clear on read, reassert per sample
// - Under-threshold flag after 128/125 ms persistence
// - Drive out-of-range flag after qualification time
// - Four DC lead-off flags after persistence time
// - Lead-off flags clear on read, reassert while true
// - Write index increments per push, wraps 0xff
// - Read index advances per read; writes need PLL
// - Almost-full when count equals 256 minus setting
// - Enabled flags drive the interrupt pin
`ifndef SFP_PARAMS_SVH
`define SFP_PARAMS_SVH

// Register addresses
`define SFP_ADDR_STATUS_ONE  8'h00
`define SFP_ADDR_STATUS_TWO  8'h01
`define SFP_ADDR_WR_INDEX    8'h08
`define SFP_ADDR_RD_INDEX    8'h09
`define SFP_ADDR_FIFO_DATA   8'h0c

// Status one bit positions
`define SFP_BIT_A_FULL       7
`define SFP_BIT_NEW_SAMPLE   5
`define SFP_BIT_FREQ_LOST    4
`define SFP_BIT_FREQ_LOCKED  3
`define SFP_BIT_PHASE_LOST   2
`define SFP_BIT_PHASE_LOCKED 1
`define SFP_BIT_UNDERVOLT    0

// Status two bit positions
`define SFP_BIT_LEAD_ON      7
`define SFP_BIT_OVER_HIGH    6
`define SFP_BIT_UNDER_LOW    5
`define SFP_BIT_DRIVE_OOR    4
`define SFP_BIT_POS_HIGH     3
`define SFP_BIT_POS_LOW      2
`define SFP_BIT_NEG_HIGH     1
`define SFP_BIT_NEG_LOW      0

// Reset values
`define SFP_RST_STATUS_ONE   8'h01
`define SFP_RST_STATUS_TWO   8'h00
`define SFP_RST_INDEX        8'h00

// Almost-full reference depth
`define SFP_FIFO_SLOTS       9'h100

// Persistence times in ms, base tick periods in ns
`define SFP_QUAL_MS_SEL0     128
`define SFP_QUAL_MS_SEL1     125
`define SFP_CLK_PERIOD_NS    8
// Qualification in mclk cycles (least time, rounded up)
`define SFP_QUAL_CYC_SEL0 \
   ((`SFP_QUAL_MS_SEL0 * 1000000 + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)
`define SFP_QUAL_CYC_SEL1 \
   ((`SFP_QUAL_MS_SEL1 * 1000000 + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)

`endif

//--- core/sfp_pkg.sv
package sfp_pkg;

   // Raw analog and PLL indications
   typedef struct packed {
      logic       freq_locked;
      logic       phase_locked;
      logic       lead_on;
      logic       over_high;
      logic       under_low;
      logic       drive_oor;
      logic [3:0] lead_off;   // pos high, pos low, neg high, neg low
   } sfp_cond_t;

   // Host register access strobes
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfp_acc_t;

   // Configuration fields from other register blocks
   typedef struct packed {
      logic [7:0] almost_full_setting;
      logic       data_read_clears_flags;
      logic       base_freq_select;
      logic       pll_enable;
      logic       shutdown_wr;
      logic [7:0] int_enable_one;
      logic [7:0] int_enable_two;
   } sfp_cfg_t;

   // Qualifier state
   typedef enum logic [1:0] {
      SFP_Q_IDLE  = 2'b00,
      SFP_Q_COUNT = 2'b01,
      SFP_Q_HELD  = 2'b11
   } sfp_qstate_t;

endpackage : sfp_pkg

//--- core/sfp_qualify.sv
`timescale 1ns/1ps
`include "sfp_params.svh"

// Persistence qualifier: output true once input held past the time
module sfp_qualify #(
   parameter int CYC_SEL0 = `SFP_QUAL_CYC_SEL0,
   parameter int CYC_SEL1 = `SFP_QUAL_CYC_SEL1
) (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // Condition
   input  wire logic sel,
   input  wire logic cond,
   output logic      qualified
);
   import sfp_pkg::*;

   typedef struct packed {
      sfp_qstate_t st;
      logic [31:0] cnt;
   } sfp_qual_state_t;

   sfp_qual_state_t s_q, s_d;
   logic [31:0]     limit;

   assign limit     = sel ? 32'(CYC_SEL1) : 32'(CYC_SEL0);
   assign qualified = (s_q.st == SFP_Q_HELD);

   // Count while condition holds; any drop restarts
   always_comb begin
      s_d = s_q;
      if (!cond) begin
         s_d.st  = SFP_Q_IDLE;
         s_d.cnt = 32'h0;
      end else begin
         unique case (s_q.st)
            SFP_Q_IDLE: begin
               s_d.st  = SFP_Q_COUNT;
               s_d.cnt = 32'h1;
            end
            SFP_Q_COUNT: begin
               // Strictly longer than the time, hence the compare past limit
               if (s_q.cnt >= limit) begin
                  s_d.st = SFP_Q_HELD;
               end else begin
                  s_d.cnt = s_q.cnt + 32'h1;
               end
            end
            SFP_Q_HELD: s_d = s_q;
            default: s_d.st = SFP_Q_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_q <= '{st: SFP_Q_IDLE, cnt: 32'h0};
      end else begin
         s_q <= s_d;
      end
   end

endmodule : sfp_qualify

//--- core/sfp_status.sv
`timescale 1ns/1ps
`include "sfp_params.svh"

// Status flags, FIFO indices and interrupt pin
module sfp_status #(
   parameter int QUAL_CYC_SEL0 = `SFP_QUAL_CYC_SEL0,
   parameter int QUAL_CYC_SEL1 = `SFP_QUAL_CYC_SEL1
) (
   // Clock and resets
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             undervolt,
   input  wire logic             soft_reset,
   // Register access
   input  wire sfp_pkg::sfp_acc_t acc,
   output logic [7:0]            rdata,
   // Configuration
   input  wire sfp_pkg::sfp_cfg_t cfg,
   // Events and conditions
   input  wire logic             sample_push,
   input  wire logic             sample_pop,
   input  wire logic             sample_sample_end,
   input  wire sfp_pkg::sfp_cond_t cond,
   // Interrupt pin
   output logic                  int_pin
);
   import sfp_pkg::*;

   typedef struct packed {
      logic [7:0] status_one;
      logic [7:0] status_two;
      logic [7:0] wr_index;
      logic [7:0] rd_index;
      logic [8:0] count;
      logic       phase_seen;
      logic       freq_seen;
      logic [1:0] thr_wait;   // Over, under: cleared, held until sample end
      logic [7:0] rdata;
   } sfp_state_t;

   sfp_state_t s_q, s_d;

   // Qualified analog conditions: over, under, drive, four lead-off
   logic [6:0] raw_cond;
   logic [6:0] qual;
   assign raw_cond = {cond.over_high, cond.under_low, cond.drive_oor, cond.lead_off};

   ////////////////////////////////////////////////////////////////////////
   // Persistence qualifiers, one per monitored condition
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_qual
         sfp_qualify #(
            .CYC_SEL0 (QUAL_CYC_SEL0),
            .CYC_SEL1 (QUAL_CYC_SEL1)
         ) u_qual (
            .mclk      (mclk),
            .rst       (rst | undervolt),
            .sel       (cfg.base_freq_select),
            .cond      (raw_cond[gi]),
            .qualified (qual[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Decoded accesses
   logic rd_one, rd_two, rd_data, wr_rd_index;
   logic almost_full, data_clr;
   logic [7:0] set_one, set_two;
   logic [8:0] thresh;
   logic [1:0] thr_hold;

   assign rd_one      = acc.rd && (acc.addr == `SFP_ADDR_STATUS_ONE);
   assign rd_two      = acc.rd && (acc.addr == `SFP_ADDR_STATUS_TWO);
   assign rd_data     = acc.rd && (acc.addr == `SFP_ADDR_FIFO_DATA);
   assign wr_rd_index = acc.wr && (acc.addr == `SFP_ADDR_RD_INDEX) && cfg.pll_enable;
   assign data_clr    = rd_data && cfg.data_read_clears_flags;
   assign thresh      = `SFP_FIFO_SLOTS - {1'b0, cfg.almost_full_setting};
   assign almost_full = (s_q.count == thresh);
   // A read that clears a set threshold flag holds it back until the next sample end
   assign thr_hold    = s_q.thr_wait | ({2{rd_two}} & s_q.status_two[6:5]);

   // Flag set terms, status one
   always_comb begin
      set_one = 8'h00;
      set_one[`SFP_BIT_A_FULL]       = almost_full;
      set_one[`SFP_BIT_NEW_SAMPLE]   = sample_push;
      set_one[`SFP_BIT_FREQ_LOST]    = !cond.freq_locked && s_q.freq_seen;
      set_one[`SFP_BIT_FREQ_LOCKED]  = cond.freq_locked;
      set_one[`SFP_BIT_PHASE_LOST]   = !cond.phase_locked && s_q.phase_seen;
      set_one[`SFP_BIT_PHASE_LOCKED] = cond.phase_locked;
   end

   // Flag set terms, status two; threshold flags refresh on sample end
   always_comb begin
      set_two = 8'h00;
      set_two[`SFP_BIT_LEAD_ON]   = cond.lead_on;
      set_two[`SFP_BIT_OVER_HIGH] = qual[6] && (sample_sample_end || !thr_hold[1]);
      set_two[`SFP_BIT_UNDER_LOW] = qual[5] && (sample_sample_end || !thr_hold[0]);
      set_two[`SFP_BIT_DRIVE_OOR] = qual[4];
      set_two[3:0]                = qual[3:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_d = s_q;
      // Lock history, so a lost flag only follows an earlier lock
      if (cond.freq_locked) begin
         s_d.freq_seen = 1'b1;
      end
      if (cond.phase_locked) begin
         s_d.phase_seen = 1'b1;
      end
      // Waiting ends at a sample end or once the condition drops
      s_d.thr_wait = sample_sample_end ? 2'b00 : (thr_hold & qual[6:5]);
      // Clears first, then sets so an event in the clearing cycle survives
      if (rd_one) begin
         s_d.status_one = 8'h00;
      end
      if (data_clr) begin
         s_d.status_one[`SFP_BIT_A_FULL]     = 1'b0;
         s_d.status_one[`SFP_BIT_NEW_SAMPLE] = 1'b0;
      end
      if (cfg.shutdown_wr) begin
         s_d.status_one[`SFP_BIT_UNDERVOLT] = 1'b0;
      end
      if (rd_two) begin
         s_d.status_two = 8'h00;
      end
      s_d.status_one = s_d.status_one | set_one;
      s_d.status_two = s_d.status_two | set_two;
      // Write index advances per push and wraps naturally
      if (sample_push) begin
         s_d.wr_index = s_q.wr_index + 8'h01;
      end
      // Host write wins over a concurrent pop
      if (wr_rd_index) begin
         s_d.rd_index = acc.wdata;
      end else if (sample_pop) begin
         s_d.rd_index = s_q.rd_index + 8'h01;
      end
      unique case ({sample_push, sample_pop && s_q.count != 9'h000})
         2'b10:   s_d.count = s_q.count + 9'h001;
         2'b01:   s_d.count = s_q.count - 9'h001;
         default: s_d.count = s_q.count;
      endcase
      // Read data registered one cycle after the strobe
      unique case (acc.addr)
         `SFP_ADDR_STATUS_ONE: s_d.rdata = s_q.status_one;
         `SFP_ADDR_STATUS_TWO: s_d.rdata = s_q.status_two;
         `SFP_ADDR_WR_INDEX:   s_d.rdata = s_q.wr_index;
         `SFP_ADDR_RD_INDEX:   s_d.rdata = s_q.rd_index;
         default:              s_d.rdata = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers; undervoltage acts like power-on reset but leaves the flag set
   always_ff @(posedge mclk) begin
      if (rst || undervolt) begin
         s_q <= '{status_one: `SFP_RST_STATUS_ONE,
                  status_two: `SFP_RST_STATUS_TWO,
                  wr_index:   `SFP_RST_INDEX,
                  rd_index:   `SFP_RST_INDEX,
                  count:      9'h000,
                  phase_seen: 1'b0,
                  freq_seen:  1'b0,
                  thr_wait:   2'b00,
                  rdata:      8'h00};
      end else if (soft_reset) begin
         // Soft reset clears state but never raises the undervoltage flag
         s_q            <= '0;
         s_q.status_one <= {7'h00, s_q.status_one[`SFP_BIT_UNDERVOLT]};
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata;

   // Interrupt: undervoltage unmaskable, others gated by enables
   assign int_pin = s_q.status_one[`SFP_BIT_UNDERVOLT]
                  | (|(s_q.status_one & cfg.int_enable_one))
                  | (|(s_q.status_two & cfg.int_enable_two));

endmodule : sfp_status

//--- dv/sfp_status_assertions.sv
`timescale 1ns/1ps
// Port-level checks on the status block
module sfp_status_chk (
   // Clock and resets
   input wire logic               mclk,
   input wire logic               rst,
   input wire logic               undervolt,
   input wire logic               soft_reset,
   // Host access and configuration
   input wire sfp_pkg::sfp_acc_t  acc,
   input wire logic [7:0]         rdata,
   input wire sfp_pkg::sfp_cfg_t  cfg,
   // Events and conditions
   input wire logic               sample_push,
   input wire logic               sample_pop,
   input wire sfp_pkg::sfp_cond_t cond,
   input wire logic               int_pin
);
   import sfp_pkg::*;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);
   // With all enables off only the undervolt flag reaches the pin
   wire no_en = cfg.int_enable_one == 8'h00 && cfg.int_enable_two == 8'h00;
   // Index resets would spoil the stepping checks
   wire keep = !soft_reset && !undervolt;
   ////////////////////////////////////////
   sequence s_push_seen;
      acc.addr == 8'h08 && sample_push && keep ##1 acc.addr == 8'h08 && keep;
   endsequence
   sequence s_rd_idx_wr(en);
      acc.wr && acc.addr == 8'h09 && cfg.pll_enable == en && !sample_pop && keep
         ##1 acc.addr == 8'h09 && keep;
   endsequence
   // Quiet long enough that no qualifier output can still be pending
   sequence s_quiet_read;
      (cond == '0)[*4] ##0 acc.rd && acc.addr == 8'h01 ##1 acc.addr == 8'h01 && cond == '0;
   endsequence
   ////////////////////////////////////////
   chk_uv_pin_forced: assert property (undervolt |=> int_pin)
      else $error("int pin low after undervolt");
   chk_uv_bit_set: assert property (
      $fell(undervolt) && acc.addr == 8'h00 && keep |=> rdata[0])
      else $error("undervolt bit not read back");
   chk_soft_keeps_uv: assert property (
      soft_reset && int_pin && no_en && !acc.rd && !cfg.shutdown_wr |=> int_pin)
      else $error("soft reset cleared undervolt flag");
   chk_shutdown_bit_clears: assert property (cfg.shutdown_wr && no_en && keep |=> !int_pin)
      else $error("shutdown write left undervolt flag");
   chk_wr_index_step: assert property (s_push_seen |=> rdata == $past(rdata) + 8'h01)
      else $error("write index did not step by one");
   chk_rd_index_lock: assert property (s_rd_idx_wr(1'b0) |=> $stable(rdata))
      else $error("read index written with pll off");
   chk_rd_index_load: assert property (s_rd_idx_wr(1'b1) |=> rdata == $past(acc.wdata, 2))
      else $error("read index write lost");
   chk_st2_clears: assert property (s_quiet_read |=> rdata == 8'h00)
      else $error("status two not cleared by read");
endmodule : sfp_status_chk

bind sfp_status sfp_status_chk sfp_status_chk_i (
   .mclk(mclk), .rst(rst), .undervolt(undervolt), .soft_reset(soft_reset), .acc(acc),
   .rdata(rdata), .cfg(cfg), .sample_push(sample_push), .sample_pop(sample_pop),
   .cond(cond), .int_pin(int_pin));

//--- dv/sfp_host_model.sv
`timescale 1ns/1ps
// Host side of register access, one strobe cycle per access
module sfp_host_model (
   // Clock and read data
   input wire logic          mclk,
   input wire logic [7:0]    rdata,
   // Access strobes
   output sfp_pkg::sfp_acc_t acc
);
   import sfp_pkg::*;
   initial acc = '0;
   // Address left in place so rdata keeps tracking it
   task automatic rd(input logic [7:0] a, output logic [7:0] dat);
      @(negedge mclk);
      acc.rd = 1'b1;
      acc.addr = a;
      @(negedge mclk);
      acc.rd = 1'b0;
      dat = rdata;
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      @(negedge mclk);
      acc.wr = 1'b1;
      acc.addr = a;
      acc.wdata = dat;
      @(negedge mclk);
      acc.wr = 1'b0;
   endtask : wr
endmodule : sfp_host_model

//--- dv/sfp_status_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the status block
module sfp_status_bench;
   import sfp_pkg::*;
   // Stimulus, driven at the falling edge
   logic       mclk = 1'b0;
   logic       rst = 1'b1;
   logic       undervolt = 1'b0;
   logic       soft_reset = 1'b0;
   logic       sample_push = 1'b0;
   logic       sample_pop = 1'b0;
   logic       sample_end = 1'b0;
   sfp_cfg_t   cfg = '0;
   sfp_cond_t  cond = '0;
   sfp_acc_t   acc;
   logic [7:0] rdata;
   logic       int_pin;
   // Model state and scoring
   logic [7:0] d;
   logic [7:0] v;
   int         n;
   int         miscompares = 0;
   int         total_checks = 0;
   // Reference model: index counters and an occupancy queue
   int         exp_wr = 0;
   int         exp_rd = 0;
   int         occ_q[$];
   logic       af_exp;
   ////////////////////////////////////////
   always #4 mclk = ~mclk;
   // Short qualification so the run stays brief
   sfp_status #(.QUAL_CYC_SEL0(8), .QUAL_CYC_SEL1(6)) sfp_status_i (
      .mclk(mclk), .rst(rst), .undervolt(undervolt), .soft_reset(soft_reset),
      .acc(acc), .rdata(rdata), .cfg(cfg), .sample_push(sample_push),
      .sample_pop(sample_pop), .sample_sample_end(sample_end), .cond(cond),
      .int_pin(int_pin));
   sfp_host_model sfp_host_model_i (.mclk(mclk), .rdata(rdata), .acc(acc));
   ////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] got;
      sfp_host_model_i.rd(a, got);
      check($sformatf("reg %h", a), got, exp);
   endtask : rd_chk
   task automatic cyc(input int k);
      repeat (k) @(negedge mclk);
   endtask : cyc
   // Push samples and track them in the model
   task automatic push(input int k);
      repeat (k) begin
         pulse(sample_push);
         occ_q.push_back(exp_wr);
         exp_wr = (exp_wr + 1) % 256;
      end
   endtask : push
   task automatic pulse(ref logic s);
      @(negedge mclk);
      s = 1'b1;
      @(negedge mclk);
      s = 1'b0;
   endtask : pulse
   task automatic wrap_up;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   // Watchdog, well past the expected run length
   initial begin
      #200000;
      miscompares++;
      wrap_up();
   end
   ////////////////////////////////////////
   initial begin
      void'($urandom(32'h9b7e));
      cyc(3);
      rst = 1'b0;
      rd_chk(8'h08, 8'h00);
      rd_chk(8'h09, 8'h00);
      rd_chk(8'h01, 8'h00);
      check("int pin", {7'h00, int_pin}, 8'h01);
      rd_chk(8'h00, 8'h01);
      rd_chk(8'h00, 8'h00);
      check("int pin", {7'h00, int_pin}, 8'h00);
      // Undervolt, soft reset and shutdown on the undervolt flag
      pulse(undervolt);
      rd_chk(8'h00, 8'h01);
      pulse(undervolt);
      pulse(soft_reset);
      rd_chk(8'h00, 8'h01);
      pulse(undervolt);
      cfg.shutdown_wr = 1'b1;
      cyc(1);
      cfg.shutdown_wr = 1'b0;
      rd_chk(8'h00, 8'h00);
      // Fill to the almost-full mark, then clear through a data read
      n = $urandom_range(40, 2);
      cfg.almost_full_setting = 8'(256 - n);
      sfp_host_model_i.rd(8'h08, d);
      push(n);
      af_exp = occ_q.size() == 256 - int'(cfg.almost_full_setting);
      rd_chk(8'h08, 8'(exp_wr));
      rd_chk(8'h00, {af_exp, 7'h20});
      rd_chk(8'h00, {af_exp, 7'h00});
      pulse(sample_pop);
      void'(occ_q.pop_front());
      exp_rd = (exp_rd + 1) % 256;
      cfg.data_read_clears_flags = 1'b1;
      sfp_host_model_i.rd(8'h0c, d);
      rd_chk(8'h00, 8'h00);
      rd_chk(8'h09, 8'(exp_rd));
      // Read index writes refused without the PLL; top bit set so it differs
      v = {1'b1, 7'($urandom)};
      sfp_host_model_i.wr(8'h09, v);
      rd_chk(8'h09, 8'(exp_rd));
      cfg.pll_enable = 1'b1;
      sfp_host_model_i.wr(8'h09, v);
      exp_rd = int'(v);
      rd_chk(8'h09, 8'(exp_rd));
      // A full lap of the write index
      sfp_host_model_i.rd(8'h08, d);
      push(256);
      rd_chk(8'h08, 8'(exp_wr));
      sfp_host_model_i.rd(8'h00, d);
      // Lock, then loss of lock
      cond.freq_locked = 1'b1;
      cond.phase_locked = 1'b1;
      cyc(2);
      rd_chk(8'h00, 8'h0a);
      rd_chk(8'h00, 8'h0a);
      cond.freq_locked = 1'b0;
      cond.phase_locked = 1'b0;
      cyc(2);
      rd_chk(8'h00, 8'h1e);
      rd_chk(8'h00, 8'h14);
      // Lead-on with its enable set
      cfg.int_enable_two = 8'h80;
      cond.lead_on = 1'b1;
      cyc(2);
      rd_chk(8'h01, 8'h80);
      rd_chk(8'h01, 8'h80);
      check("int pin", {7'h00, int_pin}, 8'h01);
      cond.lead_on = 1'b0;
      cyc(2);
      sfp_host_model_i.rd(8'h01, d);
      check("int pin", {7'h00, int_pin}, 8'h00);
      cfg.int_enable_two = 8'h00;
      // Qualified flags; condition bits line up with status two bits
      for (int i = 0; i < 7; i++) begin
         cfg.base_freq_select = i[0];
         cond = sfp_cond_t'(10'h001 << i);
         cyc(5);
         cond = '0;
         cyc(1);
         cond = sfp_cond_t'(10'h001 << i);
         cyc(2);
         rd_chk(8'h01, 8'h00);
         cyc(12);
         pulse(sample_end);
         rd_chk(8'h01, 8'h01 << i);
         rd_chk(8'h01, i > 4 ? 8'h00 : 8'h01 << i);
         pulse(sample_end);
         rd_chk(8'h01, 8'h01 << i);
         cond = '0;
         cyc(4);
         sfp_host_model_i.rd(8'h01, d);
         rd_chk(8'h01, 8'h00);
      end
      wrap_up();
   end
endmodule : sfp_status_bench
